// [verilog/rlc_pkg.sv]
// Purpose: shared constants and carriers for the radio link config bank
// Assumes: 10 MHz core clock, register access over the four-pin serial port
// Notes: one byte command then one data byte per frame
package rlc_pkg;
   // register offsets
   localparam logic [4:0] RLC_OFS_STATUS = 5'h01;
   localparam logic [4:0] RLC_OFS_INT_EN = 5'h02;
   localparam logic [4:0] RLC_OFS_LINK = 5'h03;
   localparam logic [4:0] RLC_OFS_PIPE_RX = 5'h04;
   localparam logic [4:0] RLC_OFS_PIPE_ACK = 5'h05;
   localparam logic [4:0] RLC_OFS_PIPE_VAR = 5'h06;
   localparam logic [4:0] RLC_OFS_TIMING = 5'h07;
   localparam logic [4:0] RLC_OFS_RESEND = 5'h08;
   // reset values
   localparam logic [7:0] RLC_RST_INT_EN = 8'h30;
   localparam logic [7:0] RLC_RST_LINK = 8'h33;
   localparam logic [7:0] RLC_RST_PIPE_RX = 8'hFF;
   localparam logic [7:0] RLC_RST_PIPE_ACK = 8'h00;
   localparam logic [7:0] RLC_RST_PIPE_VAR = 8'h00;
   localparam logic [7:0] RLC_RST_TIMING = 8'h00;
   localparam logic [3:0] RLC_RST_LIMIT = 4'h0;
   // writable masks, reserved bits read zero
   localparam logic [7:0] RLC_MASK_INT_EN = 8'hBF;
   localparam logic [7:0] RLC_MASK_LINK = 8'h7F;
   // field positions and the refused address length code
   localparam int RLC_BIT_POLARITY = 7;
   localparam int RLC_BIT_LIMIT_EN = 3;
   localparam int RLC_BIT_TX_EMPTY_EN = 2;
   localparam int RLC_BIT_RX_EMPTY_EN = 1;
   localparam int RLC_BIT_STRENGTH_EN = 0;
   localparam int RLC_BIT_ST_LIMIT = 3;
   localparam int RLC_BIT_ST_STRENGTH = 2;
   localparam int RLC_BIT_ST_TX_EMPTY = 1;
   localparam int RLC_BIT_ST_RX_NOT_EMPTY = 0;
   localparam logic [1:0] RLC_ADDR_LEN_BAD = 2'b00;
   // timing
   localparam int RLC_CLK_KHZ = 10000;
   localparam int RLC_UNIT_US = 250;
   localparam logic [11:0] RLC_UNIT_CYCLES = 12'((RLC_CLK_KHZ * RLC_UNIT_US) / 1000);
   // serial frame
   localparam logic [4:0] RLC_CMD_LAST_BIT = 5'd7;
   localparam logic [4:0] RLC_DATA_FIRST_BIT = 5'd8;
   localparam logic [4:0] RLC_DATA_LAST_BIT = 5'd15;
   localparam logic [4:0] RLC_FRAME_DONE = 5'd16;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] data;
   } rlc_wr_s;

   typedef struct packed {
      logic [1:0] group_addr_len;
      logic air_rate_sel;
      logic [1:0] tx_power_code;
      logic check_code_en;
      logic check_code_len;
      logic [2:0] addr_bytes;
      logic signed [5:0] tx_power_dbm;
      logic [1:0] check_bytes;
   } rlc_link_cfg_s;

   typedef enum logic [1:0] {
      RLC_T_IDLE = 2'b01,
      RLC_T_WAIT = 2'b10
   } rlc_timer_e;
endpackage : rlc_pkg

// [verilog/rlc_serial_slave.sv]
// Purpose: four-pin serial slave, mode 0, command byte then data byte
// Assumes: serial clock well below core clock/4; command bit 7 high = write
// Notes: status byte shifts out during the command byte
`timescale 1ns/1ps
module rlc_serial_slave
   import rlc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_csn,
   input wire logic i_mosi,
   input wire logic [7:0] i_status,
   input wire logic [7:0] i_rdata,
   output logic o_miso,
   output logic o_miso_oe_n,
   output logic [4:0] o_addr,
   output logic o_wr_valid,
   output rlc_wr_s o_wr
);
   logic [2:0] sclk_ff;
   logic [1:0] csn_ff;
   logic [1:0] mosi_ff;
   logic [4:0] bit_cnt_ff;
   logic [7:0] shin_ff;
   logic [7:0] shout_ff;
   logic [7:0] cmd_ff;
   logic wr_valid_ff;
   rlc_wr_s wr_ff;
   logic rise;
   logic fall;
   logic cs_s;

   // two flops before use; third stage only for edge detect
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sclk_ff <= 3'h0;
         csn_ff <= 2'h3;
         mosi_ff <= 2'h0;
      end
      else
      begin
         sclk_ff <= {sclk_ff[1:0], i_sclk};
         csn_ff <= {csn_ff[0], i_csn};
         mosi_ff <= {mosi_ff[0], i_mosi};
      end
   end

   assign cs_s = ~csn_ff[1];
   assign rise = cs_s & sclk_ff[1] & ~sclk_ff[2];
   assign fall = cs_s & ~sclk_ff[1] & sclk_ff[2];

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         bit_cnt_ff <= 5'h00;
         shin_ff <= 8'h00;
         cmd_ff <= 8'h00;
      end
      else if (!cs_s)
      begin
         bit_cnt_ff <= 5'h00;
      end
      else if (rise && bit_cnt_ff != RLC_FRAME_DONE)
      begin
         shin_ff <= {shin_ff[6:0], mosi_ff[1]};
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
         if (bit_cnt_ff == RLC_CMD_LAST_BIT)
         begin
            cmd_ff <= {shin_ff[6:0], mosi_ff[1]};
         end
      end
   end

   // read data is loaded on the falling edge that opens the data byte
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         shout_ff <= 8'h00;
      end
      else if (!cs_s)
      begin
         shout_ff <= i_status;
      end
      else if (fall)
      begin
         if (bit_cnt_ff == RLC_DATA_FIRST_BIT)
         begin
            shout_ff <= i_rdata;
         end
         else
         begin
            shout_ff <= {shout_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_valid_ff <= 1'b0;
         wr_ff <= '0;
      end
      else
      begin
         wr_valid_ff <= rise && bit_cnt_ff == RLC_DATA_LAST_BIT && cmd_ff[7];
         if (rise && bit_cnt_ff == RLC_DATA_LAST_BIT)
         begin
            wr_ff <= '{addr: cmd_ff[4:0], data: {shin_ff[6:0], mosi_ff[1]}};
         end
      end
   end

   assign o_miso = shout_ff[7];
   assign o_miso_oe_n = ~cs_s;
   assign o_addr = cmd_ff[4:0];
   assign o_wr_valid = wr_valid_ff;
   assign o_wr = wr_ff;
endmodule : rlc_serial_slave

// [verilog/rlc_resend_timer.sv]
// Purpose: acknowledge wait and resend pacing
// Assumes: baseband pulses tx done after every transmission awaiting an ack
// Notes: wait in 250 us units, unit tick from a divider
`timescale 1ns/1ps
module rlc_resend_timer
   import rlc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_new_packet,
   input wire logic i_tx_done,
   input wire logic i_ack_rcvd,
   input wire logic [3:0] i_ack_wait,
   input wire logic [3:0] i_step,
   input wire logic [3:0] i_limit,
   output logic o_resend,
   output logic o_limit_hit,
   output logic [3:0] o_count
);
   rlc_timer_e state_ff;
   logic [11:0] div_ff;
   logic [6:0] units_ff;
   logic [1:0] k_ff;
   logic [3:0] count_ff;
   logic resend_ff;
   logic limit_ff;
   logic tick;

   function automatic logic [6:0] wait_units(input logic [3:0] aw, input logic [3:0] st,
                                             input logic [1:0] k);
      logic [5:0] mul;
      // widen before the product so 3 x 15 is not cut to four bits
      mul = {4'h0, k} * {2'h0, st};
      wait_units = 7'(aw) + 7'h01 + 7'(mul);
   endfunction : wait_units

   // divider restarts with each wait so the first unit is full length
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div_ff <= 12'h000;
      end
      else if (state_ff != RLC_T_WAIT || div_ff == RLC_UNIT_CYCLES - 12'h001)
      begin
         div_ff <= 12'h000;
      end
      else
      begin
         div_ff <= div_ff + 12'h001;
      end
   end
   assign tick = state_ff == RLC_T_WAIT && div_ff == RLC_UNIT_CYCLES - 12'h001;

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= RLC_T_IDLE;
         units_ff <= 7'h00;
         k_ff <= 2'd1;
         count_ff <= 4'h0;
         resend_ff <= 1'b0;
         limit_ff <= 1'b0;
      end
      else
      begin
         resend_ff <= 1'b0;
         limit_ff <= 1'b0;
         if (i_new_packet)
         begin
            state_ff <= RLC_T_IDLE;
            count_ff <= 4'h0;
            k_ff <= 2'd1;
         end
         else
         begin
            unique case (state_ff)
               RLC_T_IDLE:
               begin
                  if (i_tx_done)
                  begin
                     units_ff <= wait_units(i_ack_wait, i_step, k_ff);
                     state_ff <= RLC_T_WAIT;
                  end
               end
               RLC_T_WAIT:
               begin
                  if (i_ack_rcvd)
                  begin
                     state_ff <= RLC_T_IDLE;
                  end
                  else if (tick && units_ff == 7'h01)
                  begin
                     state_ff <= RLC_T_IDLE;
                     if (count_ff == i_limit)
                     begin
                        limit_ff <= 1'b1;
                     end
                     else
                     begin
                        resend_ff <= 1'b1;
                        count_ff <= count_ff + 4'h1;
                        k_ff <= (k_ff == 2'd3) ? 2'd1 : k_ff + 2'd1;
                     end
                  end
                  else if (tick)
                  begin
                     units_ff <= units_ff - 7'h01;
                  end
               end
            endcase
         end
      end
   end

   assign o_resend = resend_ff;
   assign o_limit_hit = limit_ff;
   assign o_count = count_ff;
endmodule : rlc_resend_timer

// [verilog/rlc_config_regs.sv]
// Purpose: configuration bank of the packet radio baseband
// Assumes: host on four-pin serial port; baseband events on the core clock
// Notes: interrupt pin is a level, polarity chosen by software
`timescale 1ns/1ps
module rlc_config_regs
   import rlc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_csn,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe_n,
   input wire logic i_tx_fifo_empty,
   input wire logic i_rx_fifo_empty,
   input wire logic i_strength_refresh_done,
   input wire logic i_new_packet,
   input wire logic i_tx_done,
   input wire logic i_ack_rcvd,
   output rlc_link_cfg_s o_link_cfg,
   output logic [7:0] o_pipe_rx_en,
   output logic [7:0] o_pipe_auto_ack,
   output logic [7:0] o_pipe_var_len,
   output logic o_resend,
   output logic o_irq
);
   logic [7:0] int_en_ff;
   logic [7:0] link_ff;
   logic [7:0] pipe_rx_ff;
   logic [7:0] pipe_ack_ff;
   logic [7:0] pipe_var_ff;
   logic [7:0] timing_ff;
   logic [3:0] limit_ff;
   logic limit_hit_ff;
   logic strength_done_ff;
   logic irq_ff;
   rlc_link_cfg_s cfg_ff;
   logic [4:0] rd_addr;
   logic wr_valid;
   rlc_wr_s wr;
   logic [7:0] status;
   logic [7:0] rdata;
   logic [3:0] resend_count;
   logic limit_event;
   logic any_int;

   function automatic logic wr_hit(input logic v, input rlc_wr_s w, input logic [4:0] ofs);
      wr_hit = v && w.addr == ofs;
   endfunction : wr_hit

   rlc_serial_slave u_serial (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_sclk(i_sclk),
      .i_csn(i_csn),
      .i_mosi(i_mosi),
      .i_status(status),
      .i_rdata(rdata),
      .o_miso(o_miso),
      .o_miso_oe_n(o_miso_oe_n),
      .o_addr(rd_addr),
      .o_wr_valid(wr_valid),
      .o_wr(wr)
   );

   rlc_resend_timer u_timer (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_new_packet(i_new_packet),
      .i_tx_done(i_tx_done),
      .i_ack_rcvd(i_ack_rcvd),
      .i_ack_wait(timing_ff[7:4]),
      .i_step(timing_ff[3:0]),
      .i_limit(limit_ff),
      .o_resend(o_resend),
      .o_limit_hit(limit_event),
      .o_count(resend_count)
   );

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         int_en_ff <= RLC_RST_INT_EN;
      end
      else if (wr_hit(wr_valid, wr, RLC_OFS_INT_EN))
      begin
         int_en_ff <= wr.data & RLC_MASK_INT_EN;
      end
   end

   // a length code of 00 is refused so the field never holds an invalid value
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         link_ff <= RLC_RST_LINK;
      end
      else if (wr_hit(wr_valid, wr, RLC_OFS_LINK))
      begin
         link_ff[4:0] <= wr.data[4:0];
         if (wr.data[6:5] != RLC_ADDR_LEN_BAD)
         begin
            link_ff[6:5] <= wr.data[6:5];
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pipe_rx_ff <= RLC_RST_PIPE_RX;
         pipe_ack_ff <= RLC_RST_PIPE_ACK;
         pipe_var_ff <= RLC_RST_PIPE_VAR;
      end
      else
      begin
         if (wr_hit(wr_valid, wr, RLC_OFS_PIPE_RX))
         begin
            pipe_rx_ff <= wr.data;
         end
         if (wr_hit(wr_valid, wr, RLC_OFS_PIPE_ACK))
         begin
            pipe_ack_ff <= wr.data;
         end
         if (wr_hit(wr_valid, wr, RLC_OFS_PIPE_VAR))
         begin
            pipe_var_ff <= wr.data;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         timing_ff <= RLC_RST_TIMING;
         limit_ff <= RLC_RST_LIMIT;
      end
      else
      begin
         if (wr_hit(wr_valid, wr, RLC_OFS_TIMING))
         begin
            timing_ff <= wr.data;
         end
         if (wr_hit(wr_valid, wr, RLC_OFS_RESEND))
         begin
            limit_ff <= wr.data[7:4];
         end
      end
   end

   // sticky flags: a new event wins over a write-one clear in the same cycle
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         limit_hit_ff <= 1'b0;
         strength_done_ff <= 1'b0;
      end
      else
      begin
         if (limit_event)
         begin
            limit_hit_ff <= 1'b1;
         end
         else if (wr_hit(wr_valid, wr, RLC_OFS_STATUS) && wr.data[RLC_BIT_ST_LIMIT])
         begin
            limit_hit_ff <= 1'b0;
         end
         if (i_strength_refresh_done)
         begin
            strength_done_ff <= 1'b1;
         end
         else if (wr_hit(wr_valid, wr, RLC_OFS_STATUS) && wr.data[RLC_BIT_ST_STRENGTH])
         begin
            strength_done_ff <= 1'b0;
         end
      end
   end

   always_comb
   begin
      status = 8'h00;
      status[RLC_BIT_ST_LIMIT] = limit_hit_ff;
      status[RLC_BIT_ST_STRENGTH] = strength_done_ff;
      status[RLC_BIT_ST_TX_EMPTY] = i_tx_fifo_empty;
      status[RLC_BIT_ST_RX_NOT_EMPTY] = ~i_rx_fifo_empty;
   end

   // unmapped offsets read zero and ignore writes
   always_comb
   begin
      unique case (rd_addr)
         RLC_OFS_STATUS: rdata = status;
         RLC_OFS_INT_EN: rdata = int_en_ff;
         RLC_OFS_LINK: rdata = link_ff;
         RLC_OFS_PIPE_RX: rdata = pipe_rx_ff;
         RLC_OFS_PIPE_ACK: rdata = pipe_ack_ff;
         RLC_OFS_PIPE_VAR: rdata = pipe_var_ff;
         RLC_OFS_TIMING: rdata = timing_ff;
         RLC_OFS_RESEND: rdata = {limit_ff, resend_count};
         default: rdata = 8'h00;
      endcase
   end

   assign any_int = (int_en_ff[RLC_BIT_TX_EMPTY_EN] & i_tx_fifo_empty)
      | (int_en_ff[RLC_BIT_RX_EMPTY_EN] & i_rx_fifo_empty)
      | (int_en_ff[RLC_BIT_STRENGTH_EN] & strength_done_ff)
      | (int_en_ff[RLC_BIT_LIMIT_EN] & limit_hit_ff);

   // resets to the idle level of the default active-low pin
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         irq_ff <= 1'b1;
      end
      else
      begin
         irq_ff <= any_int ~^ int_en_ff[RLC_BIT_POLARITY];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cfg_ff <= '0;
      end
      else
      begin
         cfg_ff.group_addr_len <= link_ff[6:5];
         cfg_ff.air_rate_sel <= link_ff[4];
         cfg_ff.tx_power_code <= link_ff[3:2];
         cfg_ff.check_code_en <= link_ff[1];
         cfg_ff.check_code_len <= link_ff[0];
         cfg_ff.addr_bytes <= {1'b0, link_ff[6:5]} + 3'd1;
         cfg_ff.check_bytes <= link_ff[1] ? {1'b0, link_ff[0]} + 2'd1 : 2'd0;
         unique case (link_ff[3:2])
            2'b00: cfg_ff.tx_power_dbm <= -6'sd20;
            2'b01: cfg_ff.tx_power_dbm <= -6'sd14;
            2'b10: cfg_ff.tx_power_dbm <= -6'sd8;
            2'b11: cfg_ff.tx_power_dbm <= 6'sd0;
         endcase
      end
   end

   assign o_link_cfg = cfg_ff;
   assign o_pipe_rx_en = pipe_rx_ff;
   assign o_pipe_auto_ack = pipe_ack_ff;
   assign o_pipe_var_len = pipe_var_ff;
   assign o_irq = irq_ff;
endmodule : rlc_config_regs

// [tb/rlc_config_regs_props.sv]
// Purpose: port-level checks for the radio link config bank
// Assumes: 10 MHz core clock, 2500 cycles per wait unit
// Notes: decoded link outputs are trusted from the third edge after reset
`timescale 1ns/1ps
module rlc_config_regs_props
   import rlc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_csn,
   input wire logic i_tx_done,
   input wire logic i_ack_rcvd,
   input wire logic o_miso_oe_n,
   input wire rlc_link_cfg_s o_link_cfg,
   input wire logic o_resend
);
   // slack of a few cycles for the divider phase, far below one unit
   localparam int MIN_WAIT = 2497;
   localparam int MAX_WAIT = 152504;
   logic [1:0] age_ff;
   logic [17:0] since_tx_ff;
   logic armed_ff;
   logic live;
   assign live = (age_ff == 2'h2);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         age_ff <= 2'h0;
         since_tx_ff <= 18'h3FFFF;
         armed_ff <= 1'b0;
      end
      else
      begin
         age_ff <= live ? age_ff : age_ff + 2'h1;
         since_tx_ff <= i_tx_done ? 18'h0 : since_tx_ff + {17'h0, since_tx_ff != 18'h3FFFF};
         armed_ff <= i_tx_done | (armed_ff & ~i_ack_rcvd & ~o_resend);
      end
   end
   function automatic logic signed [5:0] dbm_of(input logic [1:0] c);
      case (c)
         2'h0: return -6'sh14;
         2'h1: return -6'sh0E;
         2'h2: return -6'sh08;
         default: return 6'sh00;
      endcase
   endfunction : dbm_of
   sequence s_select;
      $fell(i_csn);
   endsequence
   sequence s_deselect;
      $rose(i_csn);
   endsequence
   AST_LEN_CODE_KEPT: assert property (live |-> o_link_cfg.group_addr_len != 2'h0)
      else $error("invalid address length code on the output");
   AST_ADDR_BYTES: assert property (
      live |-> o_link_cfg.addr_bytes == {1'b0, o_link_cfg.group_addr_len} + 3'h1)
      else $error("address byte count does not match length code");
   AST_POWER_DBM: assert property (
      live |-> o_link_cfg.tx_power_dbm == dbm_of(o_link_cfg.tx_power_code))
      else $error("transmit level does not match power code");
   AST_CHECK_BYTES: assert property (
      live |-> o_link_cfg.check_bytes == (!o_link_cfg.check_code_en ? 2'h0 :
         (o_link_cfg.check_code_len ? 2'h2 : 2'h1)))
      else $error("check byte count does not match enable and length");
   AST_RESEND_MIN_WAIT: assert property (o_resend |-> since_tx_ff >= MIN_WAIT)
      else $error("resend before one wait unit");
   AST_RESEND_MAX_WAIT: assert property (o_resend |-> since_tx_ff <= MAX_WAIT)
      else $error("resend later than the longest wait");
   AST_RESEND_ARMED: assert property (o_resend |-> armed_ff ##1 !o_resend)
      else $error("resend without a pending transmission");
   AST_MISO_DRIVE: assert property (s_select |-> ##[1:4] !o_miso_oe_n)
      else $error("miso not driven after select");
   AST_MISO_RELEASE: assert property (s_deselect |-> ##[1:4] o_miso_oe_n)
      else $error("miso not released after deselect");
endmodule : rlc_config_regs_props
bind rlc_config_regs rlc_config_regs_props u_props (
   .i_core_clk(i_core_clk),
   .i_reset_n(i_reset_n),
   .i_csn(i_csn),
   .i_tx_done(i_tx_done),
   .i_ack_rcvd(i_ack_rcvd),
   .o_miso_oe_n(o_miso_oe_n),
   .o_link_cfg(o_link_cfg),
   .o_resend(o_resend)
);

// [tb/rlc_host_model.sv]
// Purpose: host end of the four-pin serial port
// Assumes: mode 0, six core cycles per half bit
// Notes: mosi idles at the inverse of its last bit, sclk stands still between frames
`timescale 1ns/1ps
module rlc_host_model
(
   input wire logic i_core_clk,
   input wire logic i_miso,
   input wire logic i_miso_oe_n,
   output logic o_sclk,
   output logic o_csn,
   output logic o_mosi
);
   logic last_miso;
   initial
   begin
      o_sclk = 1'b0;
      o_csn = 1'b1;
      o_mosi = 1'b0;
      last_miso = 1'b0;
   end
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [15:0] got);
      logic [15:0] sh;
      sh = {cmd, dat};
      sh[7] = (cmd[7] && cmd[4:0] == 5'h03) ? 1'b0 : dat[7];
      @(posedge i_core_clk);
      o_csn <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         repeat (6) @(posedge i_core_clk);
         o_sclk <= 1'b0;
         o_mosi <= sh[i];
         repeat (6) @(posedge i_core_clk);
         o_sclk <= 1'b1;
         // an undriven line must not read as a stable value
         last_miso = i_miso_oe_n ? ~last_miso : i_miso;
         got[i] = last_miso;
      end
      repeat (6) @(posedge i_core_clk);
      o_sclk <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      o_csn <= 1'b1;
      o_mosi <= ~o_mosi;
      repeat (6) @(posedge i_core_clk);
   endtask : xfer
endmodule : rlc_host_model

// [tb/test_radio_link_config_regs.sv]
// Purpose: self-checking bench for the radio link config bank
// Assumes: host model on the serial port, baseband events driven here
// Notes: waits are measured in whole units of 2500 cycles
`timescale 1ns/1ps
module test_radio_link_config_regs
   import rlc_pkg::*;
();
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [1:0] fifo;
      logic irq;
   } rlc_row_s;
   localparam int NROWS = 17;
   localparam rlc_row_s ROWS [NROWS] = '{
      '{5'h03, 8'h5A, 8'h5A, 2'h0, 1'b1}, '{5'h03, 8'h1C, 8'h5C, 2'h0, 1'b1},
      '{5'h03, 8'hE4, 8'h64, 2'h0, 1'b1}, '{5'h03, 8'h23, 8'h23, 2'h0, 1'b1},
      '{5'h04, 8'hA5, 8'hA5, 2'h0, 1'b1}, '{5'h05, 8'h3C, 8'h3C, 2'h0, 1'b1},
      '{5'h06, 8'hC3, 8'hC3, 2'h0, 1'b1}, '{5'h07, 8'h12, 8'h12, 2'h0, 1'b1},
      '{5'h08, 8'hF3, 8'hF0, 2'h0, 1'b1}, '{5'h1F, 8'h77, 8'h00, 2'h0, 1'b1},
      '{5'h02, 8'h84, 8'h84, 2'h2, 1'b1}, '{5'h02, 8'h84, 8'h84, 2'h1, 1'b0},
      '{5'h02, 8'h82, 8'h82, 2'h1, 1'b1}, '{5'h02, 8'h86, 8'h86, 2'h0, 1'b0},
      '{5'h02, 8'h06, 8'h06, 2'h2, 1'b0}, '{5'h02, 8'h06, 8'h06, 2'h0, 1'b1},
      '{5'h02, 8'hC0, 8'h80, 2'h3, 1'b0}};
   localparam logic [7:0] RST [2:8] = '{8'h30, 8'h33, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   logic core_clk, reset_n, sclk, csn, mosi, miso, miso_oe_n;
   logic tx_empty, rx_empty, strength_done, new_packet, tx_done, ack_rcvd, resend, irq;
   rlc_link_cfg_s link_cfg;
   logic [7:0] pipe_rx, pipe_ack, pipe_var, rdat;
   logic [15:0] got;
   int mismatches, checked, hits;
   rlc_host_model host (.i_core_clk(core_clk), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
      .o_sclk(sclk), .o_csn(csn), .o_mosi(mosi));
   rlc_config_regs dut (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_sclk(sclk),
      .i_csn(csn), .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
      .i_tx_fifo_empty(tx_empty), .i_rx_fifo_empty(rx_empty),
      .i_strength_refresh_done(strength_done), .i_new_packet(new_packet),
      .i_tx_done(tx_done), .i_ack_rcvd(ack_rcvd), .o_link_cfg(link_cfg),
      .o_pipe_rx_en(pipe_rx), .o_pipe_auto_ack(pipe_ack), .o_pipe_var_len(pipe_var),
      .o_resend(resend), .o_irq(irq));
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic finish_test();
      $display("counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({3'h4, a}, d, got);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      host.xfer({3'h0, a}, 8'h00, got);
      rdat = got[7:0];
   endtask : rd
   function automatic logic [7:0] port_of(input logic [4:0] a);
      case (a)
         5'h03: return {1'b0, link_cfg[17:11]};
         5'h04: return pipe_rx;
         5'h05: return pipe_ack;
         default: return pipe_var;
      endcase
   endfunction : port_of
   // units counted from the done pulse; exits on a resend or the limit interrupt
   task automatic timed(input int units, input logic exp_resend);
      int n;
      tx_done <= 1'b1;
      @(posedge core_clk);
      tx_done <= 1'b0;
      for (n = 0; n < 40000 && resend !== 1'b1 && irq !== 1'b1; n++)
         @(posedge core_clk);
      if (n >= 40000)
      begin
         mismatches++;
         finish_test();
      end
      check("wait units", (n + 100) / 2500, units);
      check("resend pulse", resend, exp_resend);
   endtask : timed
   initial
   begin
      {reset_n, tx_empty, rx_empty, strength_done, new_packet, tx_done, ack_rcvd} = 7'h0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      check("link out", link_cfg,
         {2'h1, 1'b1, 2'h0, 2'h3, 3'h2, 6'h2C, 2'h2});
      check("pipe rx", pipe_rx, 8'hFF);
      check("pipe ack", pipe_ack, 8'h00);
      check("pipe var", pipe_var, 8'h00);
      check("idle irq", irq, 1'b1);
      for (int a = 2; a <= 8; a++)
      begin
         rd(5'(a));
         check("reset value", rdat, RST[a]);
      end
      for (int r = 0; r < NROWS; r++)
      begin
         wr(ROWS[r].addr, ROWS[r].wdata);
         tx_empty <= ROWS[r].fifo[1];
         rx_empty <= ROWS[r].fifo[0];
         rd(ROWS[r].addr);
         check("readback", rdat, ROWS[r].rdata);
         if (ROWS[r].addr inside {[5'h03:5'h06]})
            check("port", port_of(ROWS[r].addr), ROWS[r].rdata);
         check("irq", irq, ROWS[r].irq);
      end
      tx_empty <= 1'b0;
      rx_empty <= 1'b0;
      wr(5'h07, 8'h11);
      wr(5'h08, 8'h30);
      wr(5'h02, 8'h88);
      new_packet <= 1'b1;
      @(posedge core_clk);
      new_packet <= 1'b0;
      for (int k = 1; k <= 4; k++)
         timed(2 + (k == 4 ? 1 : k), k < 4);
      rd(5'h08);
      check("resend count", rdat, 8'h33);
      wr(5'h01, 8'h08);
      check("irq cleared", irq, 1'b0);
      new_packet <= 1'b1;
      @(posedge core_clk);
      new_packet <= 1'b0;
      tx_done <= 1'b1;
      @(posedge core_clk);
      tx_done <= 1'b0;
      repeat (1000) @(posedge core_clk);
      ack_rcvd <= 1'b1;
      @(posedge core_clk);
      ack_rcvd <= 1'b0;
      hits = 0;
      repeat (10000) @(posedge core_clk) hits += (resend === 1'b1);
      check("cancelled resend", hits, 0);
      new_packet <= 1'b1;
      @(posedge core_clk);
      new_packet <= 1'b0;
      timed(3, 1'b1);
      wr(5'h02, 8'h81);
      strength_done <= 1'b1;
      @(posedge core_clk);
      strength_done <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("strength irq", irq, 1'b1);
      wr(5'h01, 8'h04);
      check("strength cleared", irq, 1'b0);
      // mid-run reset must restore values that the rows overwrote
      reset_n <= 1'b0;
      @(posedge core_clk);
      check("irq in reset", irq, 1'b1);
      check("pipe rx in reset", pipe_rx, 8'hFF);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(5'h02);
      check("enables after reset", rdat, 8'h30);
      finish_test();
   end
endmodule : test_radio_link_config_regs
